// File: verilog/apm_pkg.sv
package apm_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_KHZ = 40000;
  localparam int STEP_NORMAL_US = 20;
  localparam int STEP_HALF_US = 40;
  localparam int VCM_UP_US = 500;
  localparam int PWR_SETTLE_US = 1;
  localparam int STEP_NORMAL_CYC = (STEP_NORMAL_US * CLK_KHZ) / 1000;
  localparam int STEP_HALF_CYC = (STEP_HALF_US * CLK_KHZ) / 1000;
  localparam int VCM_UP_CYC_DEF = (VCM_UP_US * CLK_KHZ + 999) / 1000;
  localparam int PWR_SETTLE_CYC = (PWR_SETTLE_US * CLK_KHZ + 999) / 1000;
  localparam int STEP_CNT_W = 11;
  localparam int VCM_CNT_W = 24;
  localparam int SETTLE_CNT_W = 8;

  // ****************************************
  // register map
  // ****************************************
  localparam int ADDR_W = 6;
  localparam logic [ADDR_W-1:0] MONO_STEP_OFS = 6'h04;
  localparam logic [ADDR_W-1:0] POWER_MISC_OFS = 6'h05;

  // mono_and_softstep_control fields
  localparam int MONO_SRC_BIT = 2;
  localparam int STEP_RATE_BIT = 1;
  localparam int STEP_DONE_BIT = 0;

  // audio_power_and_misc_control fields
  localparam int GLOBAL_OFF_BIT = 15;
  localparam int CM_AUTO_BIT = 14;
  localparam int BYPASS_OFF_BIT = 13;
  localparam int HP_OFF_BIT = 12;
  localparam int MONO_OFF_BIT = 11;
  localparam int DAC_OFF_BIT = 10;
  localparam int ADCL_OFF_BIT = 9;
  localparam int ADCR_OFF_BIT = 8;
  localparam int PWR_DONE_BIT = 7;
  localparam int MICB_OFF_BIT = 6;
  localparam int OSC_ON_BIT = 5;
  localparam int CLKBUF_ON_BIT = 4;
  localparam int SYNC_MON_OFF_BIT = 3;
  localparam int SYNC_LOST_BIT = 2;
  localparam int EFFECTS_ON_BIT = 1;
  localparam int DEEMPH_ON_BIT = 0;

  // writable bits and reset value of the power register (status bits excluded)
  localparam logic [15:0] POWER_WR_MASK = 16'hff7b;
  localparam logic [15:0] POWER_RST = 16'hff40;

  // ****************************************
  // derived section enables
  // ****************************************
  localparam int SEC_N = 12;
  localparam int SEC_BYPASS = 0;
  localparam int SEC_HP = 1;
  localparam int SEC_MONO = 2;
  localparam int SEC_DAC = 3;
  localparam int SEC_ADCL = 4;
  localparam int SEC_ADCR = 5;
  localparam int SEC_LINE_IN = 6;
  localparam int SEC_MIC_PRE = 7;
  localparam int SEC_LMUX = 8;
  localparam int SEC_LVOL = 9;
  localparam int SEC_RMUX = 10;
  localparam int SEC_RVOL = 11;

  localparam int GAIN_W = 7;
  localparam logic [GAIN_W-1:0] GAIN_FLOOR = 7'h00;

endpackage : apm_pkg

// File: verilog/apm_step_if.sv
interface apm_step_if
  import apm_pkg::*;
();
  logic tick;
  logic [GAIN_W-1:0] target;
  logic mute;
  logic [GAIN_W-1:0] applied;
  logic done;

  modport ctrl (output tick, output target, output mute, input applied, input done);
  modport chan (input tick, input target, input mute, output applied, output done);
endinterface : apm_step_if

// File: verilog/apm_soft_step.sv
module apm_soft_step
  import apm_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  apm_step_if.chan step
);

  logic [GAIN_W-1:0] goal;
  logic [GAIN_W-1:0] applied_q;
  logic [GAIN_W-1:0] applied_d;
  logic done_q;

  // mute ramps down to the floor and keeps the stored target for unmute
  assign goal = step.mute ? GAIN_FLOOR : step.target;

  always_comb
  begin
    applied_d = applied_q;
    if (step.tick && applied_q < goal)
    begin
      applied_d = applied_q + 7'h01;
    end
    else if (step.tick && applied_q > goal)
    begin
      applied_d = applied_q - 7'h01;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      applied_q <= GAIN_FLOOR;
    end
    else
    begin
      applied_q <= applied_d;
    end
  end

  // a goal change shows as not-done on the next edge
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      done_q <= 1'b1;
    end
    else
    begin
      done_q <= (applied_d == goal);
    end
  end

  assign step.applied = applied_q;
  assign step.done = done_q;

endmodule : apm_soft_step

// File: verilog/apm_ctrl_regs.sv
// Operation
// - mono select 0 routes left ADC input, 1 routes headphone mono mix
// - step rate 0 steps every 20 us, 1 every 40 us
// - soft-step done reads 1 when all ramps finished, 1 after reset
// - power bits 13..8: 1 powers section down, 0 powers up
// - global off forces all sections off, stored bits kept
// - everything but the sync monitor powered down after reset; host must power up first
// - common-mode auto bit 1 follows need; 0 keeps reference on once on
// - common-mode power-up takes 500 us before done is reported
// - bypass, headphone, DAC power bits: 0 up, 1 down, reset 1
// - mono driver up powers line in, mic preamp, left mux and volume
// - left ADC up powers line in, mic preamp, left mux and volume
// - right ADC up powers line in, mic preamp, right mux and volume
// - power done reads 1 when all changes complete, 1 after reset
// - mic bias on at 0, off at 1, reset 1
// - oscillator on at 1, reset 0
// - oscillator clock buffer on at 1, reset 0
// - sync monitor runs at 0 (reset), disabled at 1
// - out-of-sync flag is sticky until the host reads the register
// - out-of-sync reads 0 when synchronised, reset 0
// - effects filter on at 1, off at 0 (reset)
// - de-emphasis on at 1, off at 0 (reset)
module apm_ctrl_regs
  import apm_pkg::*;
#(
  parameter int NCH = 4,
  parameter int VCM_UP_CYC = VCM_UP_CYC_DEF
)
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  output logic [15:0] reg_rdata_out,
  input wire logic [NCH*GAIN_W-1:0] vol_target_in,
  input wire logic [NCH-1:0] vol_mute_in,
  input wire logic sync_error_in,
  output logic [NCH*GAIN_W-1:0] gain_applied_out,
  output logic mono_src_mix_out,
  output logic [SEC_N-1:0] section_on_out,
  output logic common_mode_reference_out,
  output logic mic_bias_on_out,
  output logic crystal_osc_on_out,
  output logic osc_clock_buffer_on_out,
  output logic sync_monitor_on_out,
  output logic effects_on_out,
  output logic deemphasis_on_out
);

  // ****************************************
  // register storage
  // ****************************************
  logic wr_mono;
  logic wr_pwr;
  logic rd_pwr;
  logic mono_source_select_q;
  logic step_rate_select_q;
  logic [15:0] power_q;

  assign wr_mono = reg_wr_in && (reg_addr_in == MONO_STEP_OFS);
  assign wr_pwr = reg_wr_in && (reg_addr_in == POWER_MISC_OFS);
  assign rd_pwr = reg_rd_in && (reg_addr_in == POWER_MISC_OFS);

  // reserved mono-register bits are not stored: they carry no function
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      mono_source_select_q <= 1'b0;
      step_rate_select_q <= 1'b0;
    end
    else if (wr_mono)
    begin
      mono_source_select_q <= reg_wdata_in[MONO_SRC_BIT];
      step_rate_select_q <= reg_wdata_in[STEP_RATE_BIT];
    end
  end

  // status bits 7 and 2 are not held here, so the mask skips them
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      power_q <= POWER_RST;
    end
    else if (wr_pwr)
    begin
      power_q <= reg_wdata_in & POWER_WR_MASK;
    end
  end

  // ****************************************
  // section power
  // ****************************************
  logic global_off;
  logic [SEC_N-1:0] sect_d;
  logic [SEC_N-1:0] sect_q;
  logic adc_like_l;
  logic need_cm;

  assign global_off = power_q[GLOBAL_OFF_BIT];

  always_comb
  begin
    sect_d = '0;
    sect_d[SEC_BYPASS] = !power_q[BYPASS_OFF_BIT];
    sect_d[SEC_HP] = !power_q[HP_OFF_BIT];
    sect_d[SEC_MONO] = !power_q[MONO_OFF_BIT];
    sect_d[SEC_DAC] = !power_q[DAC_OFF_BIT];
    sect_d[SEC_ADCL] = !power_q[ADCL_OFF_BIT];
    sect_d[SEC_ADCR] = !power_q[ADCR_OFF_BIT];
    adc_like_l = sect_d[SEC_MONO] || sect_d[SEC_ADCL];
    sect_d[SEC_LINE_IN] = adc_like_l || sect_d[SEC_ADCR];
    sect_d[SEC_MIC_PRE] = adc_like_l || sect_d[SEC_ADCR];
    sect_d[SEC_LMUX] = adc_like_l;
    sect_d[SEC_LVOL] = adc_like_l;
    sect_d[SEC_RMUX] = sect_d[SEC_ADCR];
    sect_d[SEC_RVOL] = sect_d[SEC_ADCR];
    if (global_off)
    begin
      sect_d = '0;
    end
  end

  assign need_cm = sect_d[SEC_BYPASS] || sect_d[SEC_DAC] || sect_d[SEC_ADCL] ||
                   sect_d[SEC_ADCR];

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sect_q <= '0;
    end
    else
    begin
      sect_q <= sect_d;
    end
  end

  // ****************************************
  // common-mode reference
  // ****************************************
  logic cm_hold_q;
  logic cm_req;
  logic cm_q;
  logic cm_ready_q;
  logic [VCM_CNT_W-1:0] cm_cnt_q;

  // once lit with auto-off cleared, the reference stays up so later
  // power-ups skip the slow ramp
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cm_hold_q <= 1'b0;
    end
    else if (power_q[CM_AUTO_BIT] || global_off)
    begin
      cm_hold_q <= 1'b0;
    end
    else if (cm_q)
    begin
      cm_hold_q <= 1'b1;
    end
  end

  assign cm_req = !global_off && (need_cm || cm_hold_q);

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cm_q <= 1'b0;
    end
    else
    begin
      cm_q <= cm_req;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cm_cnt_q <= '0;
      cm_ready_q <= 1'b0;
    end
    else if (!cm_q)
    begin
      cm_cnt_q <= '0;
      cm_ready_q <= 1'b0;
    end
    else if (!cm_ready_q)
    begin
      if (cm_cnt_q == VCM_CNT_W'(VCM_UP_CYC - 1))
      begin
        cm_ready_q <= 1'b1;
      end
      else
      begin
        cm_cnt_q <= cm_cnt_q + 1'b1;
      end
    end
  end

  // ****************************************
  // power done
  // ****************************************
  logic [SETTLE_CNT_W-1:0] settle_q;
  logic pwr_chg;
  logic pwr_done_q;
  logic [15:0] misc_q;

  assign pwr_chg = (sect_d != sect_q) || (cm_req != cm_q) ||
                   (misc_q != (power_q & 16'h0078));

  // mic bias, oscillator, buffer and monitor changes also settle
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      misc_q <= POWER_RST & 16'h0078;
    end
    else
    begin
      misc_q <= power_q & 16'h0078;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      settle_q <= '0;
    end
    else if (pwr_chg)
    begin
      settle_q <= SETTLE_CNT_W'(PWR_SETTLE_CYC);
    end
    else if (settle_q != '0)
    begin
      settle_q <= settle_q - 1'b1;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pwr_done_q <= 1'b1;
    end
    else
    begin
      pwr_done_q <= !pwr_chg && (settle_q == '0) &&
                    (!cm_q || cm_ready_q);
    end
  end

  // ****************************************
  // sync monitor
  // ****************************************
  logic sync_lost_sticky_q;

  // a new loss in the read cycle wins, so no event is dropped
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sync_lost_sticky_q <= 1'b0;
    end
    else if (sync_error_in && !power_q[SYNC_MON_OFF_BIT])
    begin
      sync_lost_sticky_q <= 1'b1;
    end
    else if (rd_pwr)
    begin
      sync_lost_sticky_q <= 1'b0;
    end
  end

  // ****************************************
  // soft-stepping
  // ****************************************
  logic [STEP_CNT_W-1:0] tick_cnt_q;
  logic tick_q;
  logic [NCH-1:0] ch_done;
  logic step_done_q;

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end
    else if (tick_cnt_q == '0)
    begin
      tick_q <= 1'b1;
      tick_cnt_q <= step_rate_select_q ? STEP_CNT_W'(STEP_HALF_CYC - 1) :
                    STEP_CNT_W'(STEP_NORMAL_CYC - 1);
    end
    else
    begin
      tick_q <= 1'b0;
      tick_cnt_q <= tick_cnt_q - 1'b1;
    end
  end

  for (genvar i = 0; i < NCH; i++)
  begin : g_ch
    apm_step_if u_if ();
    assign u_if.tick = tick_q;
    assign u_if.target = vol_target_in[i*GAIN_W +: GAIN_W];
    assign u_if.mute = vol_mute_in[i];
    assign ch_done[i] = u_if.done;
    assign gain_applied_out[i*GAIN_W +: GAIN_W] = u_if.applied;
    apm_soft_step u_step (
      .mclk_in (mclk_in),
      .rst_n_in (rst_n_in),
      .step (u_if.chan)
    );
  end

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      step_done_q <= 1'b1;
    end
    else
    begin
      step_done_q <= &ch_done;
    end
  end

  // ****************************************
  // read port
  // ****************************************
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      reg_rdata_out <= '0;
    end
    else if (reg_rd_in)
    begin
      reg_rdata_out <= '0;
      if (reg_addr_in == MONO_STEP_OFS)
      begin
        reg_rdata_out[MONO_SRC_BIT] <= mono_source_select_q;
        reg_rdata_out[STEP_RATE_BIT] <= step_rate_select_q;
        reg_rdata_out[STEP_DONE_BIT] <= step_done_q;
      end
      else if (reg_addr_in == POWER_MISC_OFS)
      begin
        reg_rdata_out <= power_q;
        reg_rdata_out[PWR_DONE_BIT] <= pwr_done_q;
        reg_rdata_out[SYNC_LOST_BIT] <= sync_lost_sticky_q;
      end
    end
  end

  // ****************************************
  // registered outputs
  // ****************************************
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      mono_src_mix_out <= 1'b0;
      mic_bias_on_out <= 1'b0;
      crystal_osc_on_out <= 1'b0;
      osc_clock_buffer_on_out <= 1'b0;
      sync_monitor_on_out <= 1'b0;
      effects_on_out <= 1'b0;
      deemphasis_on_out <= 1'b0;
    end
    else
    begin
      mono_src_mix_out <= mono_source_select_q;
      mic_bias_on_out <= !power_q[MICB_OFF_BIT] && !global_off;
      crystal_osc_on_out <= power_q[OSC_ON_BIT];
      osc_clock_buffer_on_out <= power_q[CLKBUF_ON_BIT];
      sync_monitor_on_out <= !power_q[SYNC_MON_OFF_BIT];
      effects_on_out <= power_q[EFFECTS_ON_BIT];
      deemphasis_on_out <= power_q[DEEMPH_ON_BIT];
    end
  end

  assign section_on_out = sect_q;
  assign common_mode_reference_out = cm_q;

endmodule : apm_ctrl_regs

// File: tb/apm_ctrl_regs_properties.sv
module apm_ctrl_props
  import apm_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic sync_error_in,
  input wire logic [SEC_N-1:0] section_on_out,
  input wire logic common_mode_reference_out,
  input wire logic mic_bias_on_out,
  input wire logic crystal_osc_on_out,
  input wire logic osc_clock_buffer_on_out,
  input wire logic sync_monitor_on_out,
  input wire logic effects_on_out,
  input wire logic deemphasis_on_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************
  // helpers
  // ****************
  logic [15:0] wd1_q;
  logic [15:0] wd2_q;
  logic need;
  logic pwr_wr;
  assign need = |{section_on_out[SEC_BYPASS], section_on_out[SEC_DAC],
                  section_on_out[SEC_ADCL], section_on_out[SEC_ADCR]};
  assign pwr_wr = reg_wr_in && reg_addr_in == POWER_MISC_OFS;
  // write data delayed to the cycle the outputs settle
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wd1_q <= 16'h0000;
      wd2_q <= 16'h0000;
    end
    else
    begin
      wd1_q <= reg_wdata_in;
      wd2_q <= wd1_q;
    end
  end
  default clocking dc @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  sequence pwr_rd;
    reg_rd_in && reg_addr_in == POWER_MISC_OFS && !sync_error_in;
  endsequence
  // two idle cycles is the tightest gap the host model leaves between reads
  sequence quiet2;
    (!sync_error_in && !reg_rd_in)[*2];
  endsequence

  reserved_zero_a: assert property (reg_rd_in && reg_addr_in == MONO_STEP_OFS |=> ##1
    reg_rdata_out[15:3] == 13'h0000) else $error("mono reserved bits not zero");
  unmapped_zero_a: assert property (reg_rd_in && reg_addr_in != MONO_STEP_OFS &&
    reg_addr_in != POWER_MISC_OFS |=> ##1 reg_rdata_out == 16'h0000)
    else $error("unmapped read not zero");
  global_off_a: assert property (pwr_wr && reg_wdata_in[GLOBAL_OFF_BIT] |-> ##2
    section_on_out == '0) else $error("section on under global off");
  mic_bias_a: assert property (pwr_wr |-> ##2 mic_bias_on_out ==
    !(wd2_q[MICB_OFF_BIT] || wd2_q[GLOBAL_OFF_BIT])) else $error("mic bias wrong");
  misc_bits_a: assert property (pwr_wr |-> ##2
    {crystal_osc_on_out, osc_clock_buffer_on_out, sync_monitor_on_out, effects_on_out,
     deemphasis_on_out} == {wd2_q[5:4], !wd2_q[3], wd2_q[1:0]}) else $error("misc bits wrong");
  auto_left_a: assert property (section_on_out[SEC_MONO] || section_on_out[SEC_ADCL] |->
    &{section_on_out[SEC_LINE_IN], section_on_out[SEC_MIC_PRE], section_on_out[SEC_LMUX],
      section_on_out[SEC_LVOL]}) else $error("left dependents off");
  auto_right_a: assert property (section_on_out[SEC_ADCR] |-> &{section_on_out[SEC_LINE_IN],
    section_on_out[SEC_MIC_PRE], section_on_out[SEC_RMUX], section_on_out[SEC_RVOL]})
    else $error("right dependents off");
  cm_follow_a: assert property ($rose(need) |-> ##[0:2] common_mode_reference_out)
    else $error("reference not on");
  sync_set_a: assert property (sync_error_in && sync_monitor_on_out ##1 quiet2 ##1 pwr_rd
    |=> ##1 reg_rdata_out[SYNC_LOST_BIT]) else $error("sync flag lost");
  sync_clear_a: assert property (pwr_rd ##1 quiet2 ##1 pwr_rd |=> ##1
    !reg_rdata_out[SYNC_LOST_BIT]) else $error("sync flag not cleared");
endmodule : apm_ctrl_props

bind apm_ctrl_regs apm_ctrl_props apm_ctrl_props_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .sync_error_in(sync_error_in),
  .section_on_out(section_on_out), .common_mode_reference_out(common_mode_reference_out),
  .mic_bias_on_out(mic_bias_on_out), .crystal_osc_on_out(crystal_osc_on_out),
  .osc_clock_buffer_on_out(osc_clock_buffer_on_out), .sync_monitor_on_out(sync_monitor_on_out),
  .effects_on_out(effects_on_out), .deemphasis_on_out(deemphasis_on_out));

// File: tb/apm_host_model.sv
module apm_host_model
  import apm_pkg::*;
(
  input wire logic mclk_in,
  input wire logic [15:0] reg_rdata_in,
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [ADDR_W-1:0] reg_addr_out,
  output logic [15:0] reg_wdata_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************
  // host accesses
  // ****************
  initial
  begin
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_addr_out = 6'h3f;
    reg_wdata_out = 16'h0000;
  end
  // released lines show the inverse so stale values never look valid
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    @(negedge mclk_in);
    reg_addr_out = a;
    reg_wdata_out = d;
    reg_wr_out = 1'b1;
    @(negedge mclk_in);
    reg_wr_out = 1'b0;
    reg_addr_out = ~a;
    reg_wdata_out = ~d;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [15:0] d);
    @(negedge mclk_in);
    reg_addr_out = a;
    reg_rd_out = 1'b1;
    @(negedge mclk_in);
    reg_rd_out = 1'b0;
    reg_addr_out = ~a;
    @(negedge mclk_in);
    d = reg_rdata_in;
  endtask : rd
endmodule : apm_host_model

// File: tb/test_audio_power_and_mono_control_regs.sv
module test_audio_power_and_mono_control_regs
  import apm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ****************
  // bench
  // ****************
  logic mclk_in, rst_n_in, reg_wr_in, reg_rd_in, sync_error_in;
  logic [ADDR_W-1:0] reg_addr_in;
  logic [15:0] reg_wdata_in, reg_rdata_out, rv;
  logic [27:0] vol_target_in, gain_applied_out;
  logic [3:0] vol_mute_in;
  logic [SEC_N-1:0] section_on_out;
  logic mono_src_mix_out, common_mode_reference_out, mic_bias_on_out, crystal_osc_on_out;
  logic osc_clock_buffer_on_out, sync_monitor_on_out, effects_on_out, deemphasis_on_out;
  int failures, check_count, cyc, n;
  apm_ctrl_regs #(.NCH(4), .VCM_UP_CYC(80)) apm_ctrl_regs_inst (.mclk_in(mclk_in),
    .rst_n_in(rst_n_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .vol_target_in(vol_target_in), .vol_mute_in(vol_mute_in),
    .sync_error_in(sync_error_in), .gain_applied_out(gain_applied_out),
    .mono_src_mix_out(mono_src_mix_out), .section_on_out(section_on_out),
    .common_mode_reference_out(common_mode_reference_out),
    .mic_bias_on_out(mic_bias_on_out), .crystal_osc_on_out(crystal_osc_on_out),
    .osc_clock_buffer_on_out(osc_clock_buffer_on_out),
    .sync_monitor_on_out(sync_monitor_on_out), .effects_on_out(effects_on_out),
    .deemphasis_on_out(deemphasis_on_out));
  apm_host_model apm_host_model_inst (.mclk_in(mclk_in), .reg_rdata_in(reg_rdata_out),
    .reg_wr_out(reg_wr_in), .reg_rd_out(reg_rd_in), .reg_addr_out(reg_addr_in),
    .reg_wdata_out(reg_wdata_in));
  always #12.5 mclk_in = ~mclk_in;
  task automatic end_sim();
    if (failures == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  always @(posedge mclk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic rchk(input logic [5:0] a, input logic [15:0] e, input string nm);
    apm_host_model_inst.rd(a, rv);
    chk(nm, e, rv);
  endtask : rchk
  task automatic pw(input logic [15:0] d, input logic [11:0] s, input logic cm);
    apm_host_model_inst.wr(POWER_MISC_OFS, d);
    repeat (2) @(negedge mclk_in);
    chk("sections", {4'h0, s}, {4'h0, section_on_out});
    chk("common mode", {15'h0000, cm}, {15'h0000, common_mode_reference_out});
  endtask : pw
  task automatic wait_gain(input logic [6:0] g, output int k);
    k = 0;
    while (gain_applied_out[6:0] !== g && k < 1700)
    begin
      @(negedge mclk_in);
      k++;
    end
  endtask : wait_gain
  initial
  begin
    mclk_in = 1'b0;
    rst_n_in = 1'b0;
    sync_error_in = 1'b0;
    vol_target_in = 28'h0000000;
    vol_mute_in = 4'h0;
    repeat (20) @(negedge mclk_in);
    rst_n_in = 1'b1;
    rchk(POWER_MISC_OFS, 16'hffc0, "power reset");
    rchk(MONO_STEP_OFS, 16'h0001, "mono reset");
    chk("monitor", 16'h0001, {15'h0000, sync_monitor_on_out});
    apm_host_model_inst.wr(MONO_STEP_OFS, 16'h0006);
    rchk(MONO_STEP_OFS, 16'h0007, "mono rw");
    chk("mono src", 16'h0001, {15'h0000, mono_src_mix_out});
    vol_target_in[6:0] = 7'h02;
    repeat (4) @(negedge mclk_in);
    rchk(MONO_STEP_OFS, 16'h0006, "ramp busy");
    wait_gain(7'h01, n);
    wait_gain(7'h02, n);
    chk("half step", 16'd1600, n[15:0]);
    rchk(MONO_STEP_OFS, 16'h0007, "ramp done");
    apm_host_model_inst.wr(MONO_STEP_OFS, 16'h0000);
    vol_target_in[6:0] = 7'h00;
    wait_gain(7'h01, n);
    wait_gain(7'h00, n);
    chk("normal step", 16'd800, n[15:0]);
    chk("mono src", 16'h0000, {15'h0000, mono_src_mix_out});
    vol_target_in[13:7] = 7'h01;
    vol_mute_in[1] = 1'b1;
    repeat (900) @(negedge mclk_in);
    chk("muted gain", 16'h0000, {9'h000, gain_applied_out[13:7]});
    vol_mute_in[1] = 1'b0;
    repeat (900) @(negedge mclk_in);
    chk("unmuted gain", 16'h0001, {9'h000, gain_applied_out[13:7]});
    pw(16'h0000, 12'hfff, 1'b1);
    chk("bias", 16'h0001, {15'h0000, mic_bias_on_out});
    repeat (50) @(negedge mclk_in);
    rchk(POWER_MISC_OFS, 16'h0000, "done busy");
    repeat (50) @(negedge mclk_in);
    rchk(POWER_MISC_OFS, 16'h0080, "done set");
    pw(16'h8000, 12'h000, 1'b0);
    repeat (100) @(negedge mclk_in);
    rchk(POWER_MISC_OFS, 16'h8080, "kept bits");
    pw(16'h0000, 12'hfff, 1'b1);
    pw(16'h77c0, 12'h3c4, 1'b0);
    pw(16'h7e40, 12'hce0, 1'b1);
    pw(16'h7d40, 12'h3d0, 1'b1);
    pw(16'h3d40, 12'h3d0, 1'b1);
    pw(16'h3f40, 12'h000, 1'b1);
    pw(16'h7f7f, 12'h000, 1'b0);
    chk("misc", 16'h001b, {11'h000, crystal_osc_on_out, osc_clock_buffer_on_out,
      sync_monitor_on_out, effects_on_out, deemphasis_on_out});
    repeat (60) @(negedge mclk_in);
    rchk(POWER_MISC_OFS, 16'h7ffb, "status ignored");
    apm_host_model_inst.wr(POWER_MISC_OFS, 16'h7f40);
    repeat (60) @(negedge mclk_in);
    sync_error_in = 1'b1;
    @(negedge mclk_in);
    sync_error_in = 1'b0;
    @(negedge mclk_in);
    rchk(POWER_MISC_OFS, 16'h7fc4, "sync set");
    rchk(POWER_MISC_OFS, 16'h7fc0, "sync clear");
    apm_host_model_inst.wr(POWER_MISC_OFS, 16'h7f48);
    repeat (60) @(negedge mclk_in);
    sync_error_in = 1'b1;
    @(negedge mclk_in);
    sync_error_in = 1'b0;
    rchk(POWER_MISC_OFS, 16'h7fc8, "monitor off");
    apm_host_model_inst.wr(6'h06, 16'hffff);
    rchk(6'h06, 16'h0000, "unmapped");
    rchk(POWER_MISC_OFS, 16'h7fc8, "unmapped write");
    end_sim();
  end
endmodule : test_audio_power_and_mono_control_regs
